/* hdl/pcsg_pkg.sv */
// Package for the port control block with stop-mode gating.
// It holds the register offsets, reset values and AXI4-Lite response codes.
package pcsg_pkg;

  // Register byte offsets
  localparam logic [7:0] PCSG_OFF_DATA    = 8'h00;
  localparam logic [7:0] PCSG_OFF_OUT_EN  = 8'h04;
  localparam logic [7:0] PCSG_OFF_FUNC    = 8'h08;
  localparam logic [7:0] PCSG_OFF_OPEN_DR = 8'h28;
  localparam logic [7:0] PCSG_OFF_PULLUP  = 8'h2c;
  localparam logic [7:0] PCSG_OFF_PULLDN  = 8'h30;
  localparam logic [7:0] PCSG_OFF_IN_EN   = 8'h38;
  localparam logic [7:0] PCSG_OFF_STANDBY = 8'h40;

  // Standby control field positions
  localparam int PCSG_STBY_DRVE_BIT = 0;
  localparam int PCSG_STBY_STOP_BIT = 1;

  // Reset values
  localparam logic [31:0] PCSG_RST_ZERO = 32'h0000_0000;
  localparam logic        PCSG_RST_DRVE = 1'b0;

  // AXI4-Lite responses
  localparam logic [1:0] PCSG_RESP_OKAY   = 2'b00;
  localparam logic [1:0] PCSG_RESP_SLVERR = 2'b10;

  // Register selector
  typedef enum {
    PCSG_SEL_DATA,
    PCSG_SEL_OUT_EN,
    PCSG_SEL_FUNC,
    PCSG_SEL_OPEN_DR,
    PCSG_SEL_PULLUP,
    PCSG_SEL_PULLDN,
    PCSG_SEL_IN_EN,
    PCSG_SEL_STANDBY,
    PCSG_SEL_NONE
  } pcsg_sel_t;

endpackage : pcsg_pkg

/* hdl/pcsg_pad_if.sv */
// Interface between the register side and the pad gating logic.
// It assumes one vector bit per pin, all on the system clock.
`timescale 1ns/1ns
interface pcsg_pad_if #(
  parameter int NPINS = 8
);
  logic [NPINS-1:0] data_out;
  logic [NPINS-1:0] out_en;
  logic [NPINS-1:0] func_sel;
  logic [NPINS-1:0] open_drain;
  logic [NPINS-1:0] pull_up;
  logic [NPINS-1:0] pull_dn;
  logic [NPINS-1:0] in_en;
  logic             stop_mode;
  logic             drive_en;
  logic [NPINS-1:0] alt_out;
  logic [NPINS-1:0] alt_oe;
  logic [NPINS-1:0] dbg_valid;
  logic [NPINS-1:0] pad_o;
  logic [NPINS-1:0] pad_oe;
  logic [NPINS-1:0] pad_ie;
  logic [NPINS-1:0] pad_pu;
  logic [NPINS-1:0] pad_pd;

  modport ctrl (
    output data_out, out_en, func_sel, open_drain, pull_up, pull_dn, in_en,
    output stop_mode, drive_en, alt_out, alt_oe, dbg_valid,
    input  pad_o, pad_oe, pad_ie, pad_pu, pad_pd
  );

  modport gate (
    input  data_out, out_en, func_sel, open_drain, pull_up, pull_dn, in_en,
    input  stop_mode, drive_en, alt_out, alt_oe, dbg_valid,
    output pad_o, pad_oe, pad_ie, pad_pu, pad_pd
  );
endinterface : pcsg_pad_if

/* hdl/pcsg_pad_gate.sv */
// Per-pin pad gating: function mux, open drain, pulls and stop-mode gating.
// It assumes the pin class masks are fixed at elaboration.
`timescale 1ns/1ns
module pcsg_pad_gate #(
  parameter int               NPINS      = 8,
  parameter logic [NPINS-1:0] DEBUG_MASK = '0,
  parameter logic [NPINS-1:0] INT_MASK   = '0,
  parameter logic [NPINS-1:0] OD_MASK    = '1,
  parameter logic [NPINS-1:0] CEC_MASK   = '0
) (
  // Pad control
  pcsg_pad_if.gate pads
);

  for (genvar i = 0; i < NPINS; i++)
  begin : g_pin
    logic run_oe;
    logic run_ie;
    logic stop_oe;
    logic stop_ie;
    logic val;
    logic oe;
    logic odrain;

    // Alternate function or plain port bit
    assign val    = pads.func_sel[i] ? pads.alt_out[i] : pads.data_out[i];
    assign run_oe = pads.func_sel[i] ? (pads.out_en[i] & pads.alt_oe[i]) : pads.out_en[i];
    assign run_ie = pads.in_en[i];

    // Stop-mode gating
    always_comb
    begin
      stop_oe = pads.drive_en ? run_oe : 1'b0;
      stop_ie = pads.drive_en ? run_ie : 1'b0;
      if (DEBUG_MASK[i] && pads.func_sel[i] && pads.out_en[i])
      begin
        stop_oe = pads.dbg_valid[i];
      end
      if (INT_MASK[i] && pads.func_sel[i] && pads.in_en[i])
      begin
        stop_ie = 1'b1;
      end
    end

    assign oe     = pads.stop_mode ? stop_oe : run_oe;
    assign odrain = CEC_MASK[i] | (OD_MASK[i] & pads.open_drain[i]);

    // Open drain only pulls low
    assign pads.pad_o[i]  = odrain ? 1'b0 : val;
    assign pads.pad_oe[i] = odrain ? (oe & ~val) : oe;
    assign pads.pad_ie[i] = pads.stop_mode ? stop_ie : run_ie;
    assign pads.pad_pu[i] = pads.pull_up[i] & ~CEC_MASK[i];
    assign pads.pad_pd[i] = pads.pull_dn[i];
  end

endmodule : pcsg_pad_gate

/* hdl/pcsg_port.sv */
// Top of one general-purpose port: AXI4-Lite register slave and pad drivers.
// It assumes stop_mode, alternate-function and debug inputs come from aclk logic;
// pin levels arrive asynchronously and are synchronised here.
//
// Contract
// - A data register lets software read pin levels and write the values driven out.
// - A 1 in a pin's function-select bit routes the pin to its alternate peripheral.
// - A 1 in a pin's open-drain bit stops high drive, giving a pseudo open-drain pin.
// - Input buffers are off after reset until software enables each pin's input.
// - A per-pin output-enable bit drives the pin, and a separate bit enables input.
// - In stop mode with drive enable at 1, pins other than debug data pins in debug use keep their input and output enables.
// - In stop mode with drive enable at 0, ordinary pins lose input and output.
// - Debug data pins in debug use with output on drive in stop mode only while data is valid.
// - Interrupt pins in alternate-function use with input on keep input in stop mode; output follows drive enable.
// - The CEC pin is an N-channel open-drain output with no pull-up option.
// - Per-pin pull-up and pull-down bits engage the internal resistors.
//
// The address map and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ns
module pcsg_port
  import pcsg_pkg::*;
#(
  parameter int               NPINS        = 8,
  parameter logic [NPINS-1:0] DEBUG_MASK   = '0,
  parameter logic [NPINS-1:0] INT_MASK     = '0,
  parameter logic [NPINS-1:0] OD_MASK      = '1,
  parameter logic [NPINS-1:0] CEC_MASK     = '0,
  parameter logic [NPINS-1:0] FUNC_MASK    = '1,
  parameter logic [NPINS-1:0] RST_OUT_EN   = '0,
  parameter logic [NPINS-1:0] RST_FUNC     = '0,
  parameter logic [NPINS-1:0] RST_PULLUP   = '0,
  parameter logic [NPINS-1:0] RST_PULLDN   = '0,
  parameter logic [NPINS-1:0] RST_IN_EN    = '0
) (
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]       s_axi_awaddr,
  input  wire logic [2:0]       s_axi_awprot,
  input  wire logic             s_axi_awvalid,
  output logic                  s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0]      s_axi_wdata,
  input  wire logic [3:0]       s_axi_wstrb,
  input  wire logic             s_axi_wvalid,
  output logic                  s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]            s_axi_bresp,
  output logic                  s_axi_bvalid,
  input  wire logic             s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]       s_axi_araddr,
  input  wire logic [2:0]       s_axi_arprot,
  input  wire logic             s_axi_arvalid,
  output logic                  s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]           s_axi_rdata,
  output logic [1:0]            s_axi_rresp,
  output logic                  s_axi_rvalid,
  input  wire logic             s_axi_rready,
  // Clock generator
  input  wire logic             stop_mode,
  // Alternate peripherals
  input  wire logic [NPINS-1:0] alt_out,
  input  wire logic [NPINS-1:0] alt_oe,
  input  wire logic [NPINS-1:0] dbg_valid,
  output logic [NPINS-1:0]      alt_in,
  // Pads
  input  wire logic [NPINS-1:0] pin_i,
  output logic [NPINS-1:0]      pin_o,
  output logic [NPINS-1:0]      pin_oe,
  output logic [NPINS-1:0]      pin_ie,
  output logic [NPINS-1:0]      pin_pu,
  output logic [NPINS-1:0]      pin_pd
);

  if (NPINS < 1 || NPINS > 32)
  begin : g_bad_npins
    $error("NPINS must lie between 1 and 32");
  end

  // Register selection from a byte address
  function automatic pcsg_sel_t reg_sel(input logic [7:0] addr);
    unique case (addr)
      PCSG_OFF_DATA:    reg_sel = PCSG_SEL_DATA;
      PCSG_OFF_OUT_EN:  reg_sel = PCSG_SEL_OUT_EN;
      PCSG_OFF_FUNC:    reg_sel = PCSG_SEL_FUNC;
      PCSG_OFF_OPEN_DR: reg_sel = PCSG_SEL_OPEN_DR;
      PCSG_OFF_PULLUP:  reg_sel = PCSG_SEL_PULLUP;
      PCSG_OFF_PULLDN:  reg_sel = PCSG_SEL_PULLDN;
      PCSG_OFF_IN_EN:   reg_sel = PCSG_SEL_IN_EN;
      PCSG_OFF_STANDBY: reg_sel = PCSG_SEL_STANDBY;
      default:          reg_sel = PCSG_SEL_NONE;
    endcase
  endfunction : reg_sel

  // Byte-lane merge of a write into a pin-wide register
  function automatic logic [NPINS-1:0] merge(
    input logic [NPINS-1:0] old,
    input logic [31:0]      wdata,
    input logic [3:0]       wstrb
  );
    logic [31:0] res;
    res = PCSG_RST_ZERO;
    res[NPINS-1:0] = old;
    for (int b = 0; b < 4; b++)
    begin
      if (wstrb[b])
      begin
        res[b*8 +: 8] = wdata[b*8 +: 8];
      end
    end
    merge = res[NPINS-1:0];
  endfunction : merge

  // Pin-wide value zero-extended to a bus word
  function automatic logic [31:0] widen(input logic [NPINS-1:0] v);
    logic [31:0] res;
    res = PCSG_RST_ZERO;
    res[NPINS-1:0] = v;
    widen = res;
  endfunction : widen

  logic [NPINS-1:0] data_q;
  logic [NPINS-1:0] out_en_q;
  logic [NPINS-1:0] func_q;
  logic [NPINS-1:0] open_dr_q;
  logic [NPINS-1:0] pullup_q;
  logic [NPINS-1:0] pulldn_q;
  logic [NPINS-1:0] in_en_q;
  logic             drve_q;
  logic [NPINS-1:0] sync1_q;
  logic [NPINS-1:0] sync2_q;
  logic             aw_got_q;
  logic             w_got_q;
  logic [7:0]       awaddr_q;
  logic [31:0]      wdata_q;
  logic [3:0]       wstrb_q;
  logic             wr_fire;
  pcsg_sel_t        wr_sel;
  pcsg_sel_t        rd_sel;
  logic [31:0]      rd_word;
  logic             rd_ok;

  pcsg_pad_if #(.NPINS(NPINS)) pads ();

  // Pin synchroniser
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else
    begin
      sync1_q <= pin_i;
      sync2_q <= sync1_q;
    end
  end

  // Write address and data capture, in either order
  assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_got_q && !s_axi_bvalid;
  assign wr_fire       = aw_got_q && w_got_q;
  assign wr_sel        = reg_sel(awaddr_q);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_q <= 1'b0;
      awaddr_q <= 8'h00;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_got_q <= 1'b1;
      awaddr_q <= s_axi_awaddr;
    end
    else if (wr_fire)
    begin
      aw_got_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_got_q <= 1'b0;
      wdata_q <= PCSG_RST_ZERO;
      wstrb_q <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_got_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end
    else if (wr_fire)
    begin
      w_got_q <= 1'b0;
    end
  end

  // Write response
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= PCSG_RESP_OKAY;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wr_sel == PCSG_SEL_NONE) ? PCSG_RESP_SLVERR : PCSG_RESP_OKAY;
    end
    else if (s_axi_bready)
    begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Port registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      data_q    <= '0;
      out_en_q  <= RST_OUT_EN;
      func_q    <= RST_FUNC;
      open_dr_q <= '0;
      pullup_q  <= RST_PULLUP & ~CEC_MASK;
      pulldn_q  <= RST_PULLDN;
      in_en_q   <= RST_IN_EN;
      drve_q    <= PCSG_RST_DRVE;
    end
    else if (wr_fire)
    begin
      unique case (wr_sel)
        PCSG_SEL_DATA:    data_q    <= merge(data_q, wdata_q, wstrb_q);
        PCSG_SEL_OUT_EN:  out_en_q  <= merge(out_en_q, wdata_q, wstrb_q);
        PCSG_SEL_FUNC:    func_q    <= merge(func_q, wdata_q, wstrb_q) & FUNC_MASK;
        PCSG_SEL_OPEN_DR: open_dr_q <= merge(open_dr_q, wdata_q, wstrb_q) & OD_MASK;
        PCSG_SEL_PULLUP:  pullup_q  <= merge(pullup_q, wdata_q, wstrb_q) & ~CEC_MASK;
        PCSG_SEL_PULLDN:  pulldn_q  <= merge(pulldn_q, wdata_q, wstrb_q);
        PCSG_SEL_IN_EN:   in_en_q   <= merge(in_en_q, wdata_q, wstrb_q);
        PCSG_SEL_STANDBY:
        begin
          if (wstrb_q[0])
          begin
            drve_q <= wdata_q[PCSG_STBY_DRVE_BIT];
          end
        end
        PCSG_SEL_NONE:    ;
      endcase
    end
  end

  // Read path
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_sel        = reg_sel(s_axi_araddr);

  always_comb
  begin
    rd_word = PCSG_RST_ZERO;
    rd_ok   = 1'b1;
    unique case (rd_sel)
      PCSG_SEL_DATA:    rd_word = widen((sync2_q & pads.pad_ie) | (data_q & ~pads.pad_ie));
      PCSG_SEL_OUT_EN:  rd_word = widen(out_en_q);
      PCSG_SEL_FUNC:    rd_word = widen(func_q);
      PCSG_SEL_OPEN_DR: rd_word = widen(open_dr_q);
      PCSG_SEL_PULLUP:  rd_word = widen(pullup_q);
      PCSG_SEL_PULLDN:  rd_word = widen(pulldn_q);
      PCSG_SEL_IN_EN:   rd_word = widen(in_en_q);
      PCSG_SEL_STANDBY:
      begin
        rd_word[PCSG_STBY_DRVE_BIT] = drve_q;
        rd_word[PCSG_STBY_STOP_BIT] = stop_mode;
      end
      PCSG_SEL_NONE:    rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= PCSG_RST_ZERO;
      s_axi_rresp  <= PCSG_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_ok ? PCSG_RESP_OKAY : PCSG_RESP_SLVERR;
    end
    else if (s_axi_rready)
    begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Pad gating
  assign pads.data_out   = data_q;
  assign pads.out_en     = out_en_q;
  assign pads.func_sel   = func_q;
  assign pads.open_drain = open_dr_q;
  assign pads.pull_up    = pullup_q;
  assign pads.pull_dn    = pulldn_q;
  assign pads.in_en      = in_en_q;
  assign pads.stop_mode  = stop_mode;
  assign pads.drive_en   = drve_q;
  assign pads.alt_out    = alt_out;
  assign pads.alt_oe     = alt_oe;
  assign pads.dbg_valid  = dbg_valid;

  pcsg_pad_gate #(
    .NPINS      (NPINS),
    .DEBUG_MASK (DEBUG_MASK),
    .INT_MASK   (INT_MASK),
    .OD_MASK    (OD_MASK),
    .CEC_MASK   (CEC_MASK)
  ) u_gate (
    .pads (pads.gate)
  );

  // Registered pad outputs
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      pin_o  <= '0;
      pin_oe <= RST_OUT_EN & ~(OD_MASK & '0);
      pin_ie <= '0;
      pin_pu <= RST_PULLUP & ~CEC_MASK;
      pin_pd <= RST_PULLDN;
      alt_in <= '0;
    end
    else
    begin
      pin_o  <= pads.pad_o;
      pin_oe <= pads.pad_oe;
      pin_ie <= pads.pad_ie;
      pin_pu <= pads.pad_pu;
      pin_pd <= pads.pad_pd;
      alt_in <= sync2_q & pads.pad_ie & func_q;
    end
  end

endmodule : pcsg_port

/* verif/pcsg_port_asserts.sv */
// Checker for pcsg_port: bus answers and stop-mode pad gating.
// Bound to pcsg_port, sees its ports only; tracks the drive-enable bit from bus writes.
`timescale 1ns/1ns
module pcsg_port_asserts
  import pcsg_pkg::*;
#(
  parameter int               NPINS      = 8,
  parameter logic [NPINS-1:0] DEBUG_MASK = '0,
  parameter logic [NPINS-1:0] INT_MASK   = '0,
  parameter logic [NPINS-1:0] CEC_MASK   = '0
) (
  // Clock and reset
  input wire logic             aclk,
  input wire logic             aresetn,
  // Write channels
  input wire logic [7:0]       s_axi_awaddr,
  input wire logic             s_axi_awvalid,
  input wire logic             s_axi_awready,
  input wire logic [31:0]      s_axi_wdata,
  input wire logic [3:0]       s_axi_wstrb,
  input wire logic             s_axi_wvalid,
  input wire logic             s_axi_wready,
  input wire logic [1:0]       s_axi_bresp,
  input wire logic             s_axi_bvalid,
  input wire logic             s_axi_bready,
  // Read channels
  input wire logic [7:0]       s_axi_araddr,
  input wire logic             s_axi_arvalid,
  input wire logic             s_axi_arready,
  input wire logic [31:0]      s_axi_rdata,
  input wire logic [1:0]       s_axi_rresp,
  input wire logic             s_axi_rvalid,
  input wire logic             s_axi_rready,
  // Mode and pads
  input wire logic             stop_mode,
  input wire logic [NPINS-1:0] dbg_valid,
  input wire logic [NPINS-1:0] pin_o,
  input wire logic [NPINS-1:0] pin_oe,
  input wire logic [NPINS-1:0] pin_ie,
  input wire logic [NPINS-1:0] pin_pu
);
  logic [7:0] aw_q;
  logic       w_q;
  logic       drve_q;
  logic       bv_q;
  logic       hit;
  logic       drve_eff;

  // Drive enable as the register holds it now
  assign hit      = s_axi_bvalid && !bv_q && aw_q == PCSG_OFF_STANDBY
                    && s_axi_bresp == PCSG_RESP_OKAY;
  assign drve_eff = hit ? w_q : drve_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_q   <= 8'h00;
      w_q    <= 1'b0;
      drve_q <= 1'b0;
      bv_q   <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
        aw_q <= s_axi_awaddr;
      if (s_axi_wvalid && s_axi_wready)
        w_q <= s_axi_wstrb[0] ? s_axi_wdata[0] : drve_q;
      drve_q <= drve_eff;
      bv_q   <= s_axi_bvalid;
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_reset_input_off: assert property ($rose(aresetn) |-> pin_ie == '0)
    else $error("input buffers on after reset");
  a_stop_gate_off: assert property (stop_mode && !drve_eff |=>
    (pin_ie & ~INT_MASK) == '0 && (pin_oe & ~DEBUG_MASK) == '0)
    else $error("pad enabled in stop with drive enable clear");
  a_debug_valid: assert property (stop_mode && !drve_eff |=>
    (pin_oe & DEBUG_MASK & ~$past(dbg_valid)) == '0)
    else $error("debug pin driven without valid data");
  a_cec_no_high: assert property ((pin_o & CEC_MASK) == '0 && (pin_pu & CEC_MASK) == '0)
    else $error("open-drain pin drives high or pulls up");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready
    && s_axi_araddr == 8'h10 |=> s_axi_rresp == PCSG_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
endmodule : pcsg_port_asserts

bind pcsg_port pcsg_port_asserts #(
  .NPINS(NPINS), .DEBUG_MASK(DEBUG_MASK), .INT_MASK(INT_MASK), .CEC_MASK(CEC_MASK)
) i_asserts (
  .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
  .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .stop_mode, .dbg_valid, .pin_o, .pin_oe, .pin_ie, .pin_pu
);

/* verif/pcsg_board.sv */
// Board side of the port pins: pulls, an external driver and floating lines.
// A floating pin shows a level that flips every cycle.
`timescale 1ns/1ns
module pcsg_board #(
  parameter int NPINS = 8
) (
  // Clock
  input  wire logic             aclk,
  // Device pads
  input  wire logic [NPINS-1:0] pin_o,
  input  wire logic [NPINS-1:0] pin_oe,
  input  wire logic [NPINS-1:0] pin_pu,
  input  wire logic [NPINS-1:0] pin_pd,
  // Board drivers
  input  wire logic [NPINS-1:0] ext_drv,
  input  wire logic [NPINS-1:0] ext_val,
  output logic [NPINS-1:0]      pin_i
);
  logic [NPINS-1:0] float_q = '0;

  always_ff @(posedge aclk)
    float_q <= ~float_q;

  always_comb
    for (int i = 0; i < NPINS; i++)
      pin_i[i] = pin_oe[i] ? pin_o[i] : ext_drv[i] ? ext_val[i] :
                 pin_pu[i] ? 1'b1 : pin_pd[i] ? 1'b0 : float_q[i];
endmodule : pcsg_board

/* verif/pcsg_port_bench.sv */
// Testbench for pcsg_port: register access over the bus and pad states.
// Uses pcsg_board as the far side of the pins.
`timescale 1ns/1ns
module pcsg_port_bench;
  import pcsg_pkg::*;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, stop_mode = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [7:0]  alt_out = 8'h00, alt_oe = 8'h00, dbg_valid = 8'h00;
  logic [7:0]  ext_drv = 8'h00, ext_val = 8'h00;
  logic [7:0]  alt_in, pin_i, pin_o, pin_oe, pin_ie, pin_pu, pin_pd;
  logic [7:0]  offs [8] = '{PCSG_OFF_DATA, PCSG_OFF_OUT_EN, PCSG_OFF_FUNC, PCSG_OFF_OPEN_DR,
                            PCSG_OFF_PULLUP, PCSG_OFF_PULLDN, PCSG_OFF_IN_EN, PCSG_OFF_STANDBY};
  int          err_count = 0;
  int          check_count = 0;

  pcsg_port #(
    .DEBUG_MASK(8'h01), .INT_MASK(8'h02), .CEC_MASK(8'h80)
  ) i_dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .stop_mode,
    .alt_out, .alt_oe, .dbg_valid, .alt_in, .pin_i, .pin_o, .pin_oe, .pin_ie, .pin_pu, .pin_pd
  );

  pcsg_board i_board (
    .aclk, .pin_o, .pin_oe, .pin_pu, .pin_pd, .ext_drv, .ext_val, .pin_i
  );

  initial
    forever #5 aclk = ~aclk;

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : close_out

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  task automatic pad(input logic [7:0] seen, input logic [7:0] exp);
    check({24'h0, seen}, {24'h0, exp});
  endtask : pad

  task automatic step(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask : step

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1)
      begin
        s_axi_bready <= 1'b0;
        check({30'h0, s_axi_bresp}, {30'h0, er});
        break;
      end
      if (n > 40)
      begin
        err_count++;
        close_out();
      end
    end
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1)
      begin
        s_axi_rready <= 1'b0;
        check(s_axi_rdata, exp);
        check({30'h0, s_axi_rresp}, {30'h0, er});
        break;
      end
      if (n > 40)
      begin
        err_count++;
        close_out();
      end
    end
  endtask : rd

  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    step(1);
    pad(pin_ie, 8'h00);
    pad(pin_oe, 8'h00);
    foreach (offs[i])
      rd(offs[i], 32'h0, PCSG_RESP_OKAY);
    rd(8'h10, 32'h0, PCSG_RESP_SLVERR);
    wr(8'h14, 32'hff, PCSG_RESP_SLVERR);
    // Plain port output, then open drain on pin 0
    wr(PCSG_OFF_DATA, 32'ha5, PCSG_RESP_OKAY);
    // No byte lane enabled leaves the data register alone
    @(posedge aclk);
    s_axi_wstrb <= 4'h0;
    wr(PCSG_OFF_DATA, 32'hff, PCSG_RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(PCSG_OFF_DATA, 32'ha5, PCSG_RESP_OKAY);
    wr(PCSG_OFF_OUT_EN, 32'h0f, PCSG_RESP_OKAY);
    step(1);
    pad(pin_oe, 8'h0f);
    pad(pin_o, 8'h25);
    wr(PCSG_OFF_OPEN_DR, 32'h01, PCSG_RESP_OKAY);
    step(1);
    pad(pin_o, 8'h24);
    pad(pin_oe, 8'h0e);
    wr(PCSG_OFF_DATA, 32'ha4, PCSG_RESP_OKAY);
    step(1);
    pad(pin_oe, 8'h0f);
    wr(PCSG_OFF_OPEN_DR, 32'h0, PCSG_RESP_OKAY);
    // Board drives the upper nibble
    @(posedge aclk);
    ext_drv <= 8'hf0;
    ext_val <= 8'h30;
    wr(PCSG_OFF_IN_EN, 32'hf0, PCSG_RESP_OKAY);
    step(4);
    pad(pin_ie, 8'hf0);
    rd(PCSG_OFF_DATA, 32'h34, PCSG_RESP_OKAY);
    wr(PCSG_OFF_PULLUP, 32'hff, PCSG_RESP_OKAY);
    wr(PCSG_OFF_PULLDN, 32'h0f, PCSG_RESP_OKAY);
    step(1);
    pad(pin_pu, 8'h7f);
    pad(pin_pd, 8'h0f);
    rd(PCSG_OFF_PULLUP, 32'h7f, PCSG_RESP_OKAY);
    // Alternate functions on pins 0 to 2
    @(posedge aclk);
    alt_oe <= 8'h06;
    dbg_valid <= 8'h01;
    wr(PCSG_OFF_FUNC, 32'h07, PCSG_RESP_OKAY);
    step(1);
    pad(pin_o & 8'h0f, 8'h00);
    pad(pin_oe, 8'h0e);
    wr(PCSG_OFF_IN_EN, 32'hf3, PCSG_RESP_OKAY);
    step(1);
    pad(alt_in, 8'h01);
    // Stop mode, drive enable clear, then set
    @(posedge aclk);
    stop_mode <= 1'b1;
    step(2);
    pad(pin_oe, 8'h01);
    pad(pin_ie, 8'h02);
    @(posedge aclk);
    dbg_valid <= 8'h00;
    step(2);
    pad(pin_oe, 8'h00);
    wr(PCSG_OFF_STANDBY, 32'h1, PCSG_RESP_OKAY);
    step(1);
    pad(pin_oe, 8'h0e);
    pad(pin_ie, 8'hf3);
    rd(PCSG_OFF_STANDBY, 32'h3, PCSG_RESP_OKAY);
    @(posedge aclk);
    stop_mode <= 1'b0;
    step(2);
    pad(pin_oe, 8'h0e);
    // Debug and alternate pins handed back to port use
    wr(PCSG_OFF_FUNC, 32'h0, PCSG_RESP_OKAY);
    step(1);
    pad(pin_oe, 8'h0f);
    pad(pin_o, 8'h24);
    pad(alt_in, 8'h00);
    close_out();
  end
endmodule : pcsg_port_bench
